/* File: inc/pic_host_pkg.sv */
// package: field layouts, strobe timing and command codes for the interrupt controller host
package pic_host_pkg;
    // word-one bit positions
    localparam int W1_FOURTH_BIT = 0;
    localparam int W1_SINGLE_BIT = 1;
    localparam int W1_INTERVAL_BIT = 2;
    localparam int W1_LEVEL_BIT = 3;
    localparam int W1_MARK_BIT = 4;
    // word-four bit positions
    localparam int W4_CPU_BIT = 0;
    localparam int W4_AUTO_BIT = 1;
    localparam int W4_MS_BIT = 2;
    localparam int W4_BUF_BIT = 3;
    localparam int W4_NEST_BIT = 4;
    // op word three bits and op word selectors in d4..d3
    localparam int W3_SMM_BIT = 5;
    localparam int W3_SPECIAL_MASK_WRITE_EN_BIT = 6;
    localparam logic [1:0] OP_TWO_SEL = 2'h0;
    localparam logic [1:0] OP_THREE_SEL = 2'h1;
    localparam logic [7:0] CALL_OPCODE = 8'hcd;
    localparam logic [7:0] MASK_INIT = 8'h00;
    localparam logic [2:0] SLAVE_ID_INIT = 3'h7;
    // axi register byte offsets
    localparam logic [7:0] CMD_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] VEC_OFF = 8'h08;
    localparam logic [7:0] SHADOW_OFF = 8'h0c;
    localparam logic [7:0] MASK_OFF = 8'h10;
    // command codes in cmd bits 10..8
    localparam logic [2:0] CMD_WR_A0 = 3'h0;
    localparam logic [2:0] CMD_WR_A1 = 3'h1;
    localparam logic [2:0] CMD_ACK = 3'h2;
    localparam logic [2:0] CMD_RD_A1 = 3'h3;
    // strobe timing
    localparam int CLK_NS = 40;
    localparam int STROBE_NS = 160;
    localparam int SETUP_NS = 80;
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD = 3'b011,
        ST_DONE = 3'b100
    } bus_state_t;
    typedef enum logic [2:0] {
        INIT_NONE = 3'b000,
        INIT_TWO = 3'b001,
        INIT_THREE = 3'b010,
        INIT_FOUR = 3'b011,
        INIT_READY = 3'b100
    } init_state_t;
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic a0;
        logic ack_n;
        logic [7:0] dout;
        logic doe;
    } pic_pins_t;
    typedef struct packed {
        logic level_trigger_sel;
        logic call_interval_sel;
        logic single_device_flag;
        logic fourth_word_needed;
        logic special_nesting_en;
        logic auto_end_service;
        logic cpu_family_sel;
        logic buffered;
        logic master_sel;
        logic special_mask_sel;
        logic [7:0] vector_base;
        logic [7:0] cascade_word;
    } shadow_t;
endpackage : pic_host_pkg

/* File: logic/pic_host_ctrl.sv */
// host controller driving the interrupt controller pins from axi4-lite commands
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - in 8-bit cpu mode issue three acknowledge pulses; first returns call opcode
// - 16-bit mode uses two acknowledge cycles; first leaves data bus floating
// - host initializes with two to four writes before operation words
// - single bit skips word three; fourth bit demands word four
// - a0=1 writes load mask or init words; a0=0 d4..d3 pick op words
module pic_host_ctrl
    import pic_host_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // device pins
    output logic cs_n,
    output logic wr_n,
    output logic rd_n,
    output logic a0,
    output logic intr_ack_strobe_n,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [7:0] data_in,
    input wire logic intr_req
);
    logic rst_meta_q, rst_n_q;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // bus sequencer and axi state
    bus_state_t st_q, st_d;
    init_state_t init_q, init_d;
    shadow_t sh_q, sh_d;
    pic_pins_t pin_q, pin_d;
    logic [3:0] cnt_q, cnt_d;
    logic [2:0] op_q, op_d;
    logic [7:0] byte_q, byte_d;
    logic [7:0] mask_q, mask_d;
    logic [1:0] ack_left_q, ack_left_d;
    logic [23:0] vec_q, vec_d;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [1:0] ws_q, ws_d;

    function automatic logic busy_f(input bus_state_t s, input logic [1:0] left);
        busy_f = (s != ST_IDLE) || (left != 2'h0);
    endfunction : busy_f

    always_comb
    begin
        st_d = st_q;
        init_d = init_q;
        sh_d = sh_q;
        pin_d = pin_q;
        cnt_d = cnt_q;
        op_d = op_q;
        byte_d = byte_q;
        mask_d = mask_q;
        ack_left_d = ack_left_q;
        vec_d = vec_q;
        aw_d = aw_q;
        w_d = w_q;
        bv_d = bv_q;
        rv_d = rv_q;
        awa_d = awa_q;
        wd_d = wd_q;
        rd_d = rd_q;
        br_d = br_q;
        rr_d = rr_q;
        ws_d = ws_q;
        if (s_awvalid && !aw_q)
        begin
            aw_d = 1'b1;
            awa_d = s_awaddr;
        end
        if (s_wvalid && !w_q)
        begin
            w_d = 1'b1;
            wd_d = s_wdata;
            // strobes kept with the data: the master may move them once w is taken
            ws_d = s_wstrb[1:0];
        end
        if (bv_q && s_bready)
            bv_d = 1'b0;
        if (rv_q && s_rready)
            rv_d = 1'b0;
        // write decode: only the command register starts a pin cycle
        if (aw_q && w_q && !bv_q)
        begin
            br_d = 2'h2;
            if (awa_q == CMD_OFF)
            begin
                if (!busy_f(st_q, ack_left_q) && ws_q == 2'h3)
                begin
                    br_d = 2'h0;
                    op_d = wd_q[10:8];
                    byte_d = wd_q[7:0];
                    st_d = ST_SETUP;
                    cnt_d = SETUP_CYC;
                    if (wd_q[10:8] == CMD_ACK)
                    begin
                        ack_left_d = sh_q.cpu_family_sel ? 2'h2 : 2'h3;
                        vec_d = 24'h000000;
                    end
                end
            end
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
        end
        if (s_arvalid && !rv_q)
        begin
            rv_d = 1'b1;
            rr_d = 2'h0;
            if (s_araddr == STAT_OFF)
                rd_d = {24'h0, intr_req, busy_f(st_q, ack_left_q), ack_left_q, 1'b0, init_q};
            else if (s_araddr == VEC_OFF)
                rd_d = {8'h00, vec_q};
            else if (s_araddr == SHADOW_OFF)
                rd_d = {6'h00, sh_q.level_trigger_sel, sh_q.call_interval_sel,
                        sh_q.single_device_flag, sh_q.fourth_word_needed,
                        sh_q.special_nesting_en, sh_q.auto_end_service,
                        sh_q.cpu_family_sel, sh_q.buffered, sh_q.master_sel,
                        sh_q.special_mask_sel, sh_q.vector_base, sh_q.cascade_word};
            else if (s_araddr == MASK_OFF)
                rd_d = {24'h0, mask_q};
            else
            begin
                rd_d = 32'h0;
                rr_d = 2'h2;
            end
        end
        // pin sequencer: setup, strobe low, hold
        case (st_q)
            ST_IDLE:
            begin
                if (ack_left_q != 2'h0)
                begin
                    st_d = ST_SETUP;
                    cnt_d = SETUP_CYC;
                end
            end
            ST_SETUP:
            begin
                pin_d.cs_n = (op_q == CMD_ACK);
                pin_d.a0 = (op_q != CMD_WR_A0);
                pin_d.dout = byte_q;
                pin_d.doe = (op_q == CMD_WR_A0) || (op_q == CMD_WR_A1);
                cnt_d = cnt_q - 4'h1;
                // pins stand a full setup span before the strobe falls
                if (cnt_q == 4'h0)
                begin
                    st_d = ST_STROBE;
                    cnt_d = STROBE_CYC;
                    pin_d.wr_n = !pin_d.doe;
                    pin_d.rd_n = (op_q != CMD_RD_A1);
                    pin_d.ack_n = (op_q != CMD_ACK);
                end
            end
            ST_STROBE:
            begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1)
                begin
                    st_d = ST_HOLD;
                    pin_d.wr_n = 1'b1;
                    pin_d.rd_n = 1'b1;
                    pin_d.ack_n = 1'b1;
                    if (op_q == CMD_RD_A1)
                        mask_d = data_in;
                    if (op_q == CMD_ACK)
                    begin
                        // bytes shift in; first 16-bit cycle floats, capture kept
                        vec_d = {vec_q[15:0], data_in};
                        ack_left_d = ack_left_q - 2'h1;
                    end
                end
            end
            ST_HOLD:
            begin
                pin_d.cs_n = 1'b1;
                pin_d.doe = 1'b0;
                st_d = ST_DONE;
                if (op_q == CMD_WR_A0 && byte_q[W1_MARK_BIT])
                begin
                    // word one restarts the sequence and defaults; word-four fields reset only when the fourth bit is clear
                    sh_d.level_trigger_sel = byte_q[W1_LEVEL_BIT];
                    sh_d.call_interval_sel = byte_q[W1_INTERVAL_BIT];
                    sh_d.single_device_flag = byte_q[W1_SINGLE_BIT];
                    sh_d.fourth_word_needed = byte_q[W1_FOURTH_BIT];
                    sh_d.special_mask_sel = 1'b0;
                    sh_d.cascade_word = {5'h00, SLAVE_ID_INIT};
                    mask_d = MASK_INIT;
                    if (!byte_q[W1_FOURTH_BIT])
                    begin
                        sh_d.special_nesting_en = 1'b0;
                        sh_d.auto_end_service = 1'b0;
                        sh_d.cpu_family_sel = 1'b0;
                        sh_d.buffered = 1'b0;
                        sh_d.master_sel = 1'b0;
                    end
                    init_d = INIT_TWO;
                end
                else if (op_q == CMD_WR_A0 && byte_q[4:3] == OP_THREE_SEL)
                begin
                    if (byte_q[W3_SPECIAL_MASK_WRITE_EN_BIT])
                        sh_d.special_mask_sel = byte_q[W3_SMM_BIT];
                end
                else if (op_q == CMD_WR_A1)
                begin
                    // a0=1 writes walk the init order, then load the mask
                    case (init_q)
                        INIT_TWO:
                        begin
                            sh_d.vector_base = byte_q;
                            if (!sh_q.single_device_flag)
                                init_d = INIT_THREE;
                            else if (sh_q.fourth_word_needed)
                                init_d = INIT_FOUR;
                            else
                                init_d = INIT_READY;
                        end
                        INIT_THREE:
                        begin
                            sh_d.cascade_word = byte_q;
                            init_d = sh_q.fourth_word_needed ? INIT_FOUR : INIT_READY;
                        end
                        INIT_FOUR:
                        begin
                            sh_d.cpu_family_sel = byte_q[W4_CPU_BIT];
                            sh_d.auto_end_service = byte_q[W4_AUTO_BIT];
                            sh_d.special_nesting_en = byte_q[W4_NEST_BIT];
                            sh_d.buffered = byte_q[W4_BUF_BIT];
                            sh_d.master_sel = byte_q[W4_BUF_BIT] & byte_q[W4_MS_BIT];
                            init_d = INIT_READY;
                        end
                        default:
                            mask_d = byte_q;
                    endcase
                end
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            st_q <= ST_IDLE;
            init_q <= INIT_NONE;
            sh_q <= '0;
            pin_q <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, a0: 1'b0, ack_n: 1'b1,
                       dout: 8'h00, doe: 1'b0};
            cnt_q <= 4'h0;
            op_q <= 3'h0;
            byte_q <= 8'h00;
            mask_q <= MASK_INIT;
            ack_left_q <= 2'h0;
            vec_q <= 24'h0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            rd_q <= 32'h0;
            br_q <= 2'h0;
            rr_q <= 2'h0;
            ws_q <= 2'h0;
        end
        else
        begin
            st_q <= st_d;
            init_q <= init_d;
            sh_q <= sh_d;
            pin_q <= pin_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            byte_q <= byte_d;
            mask_q <= mask_d;
            ack_left_q <= ack_left_d;
            vec_q <= vec_d;
            aw_q <= aw_d;
            w_q <= w_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            br_q <= br_d;
            rr_q <= rr_d;
            ws_q <= ws_d;
        end
    end

    assign s_awready = !aw_q;
    assign s_wready = !w_q;
    assign s_bvalid = bv_q;
    assign s_bresp = br_q;
    assign s_arready = !rv_q;
    assign s_rvalid = rv_q;
    assign s_rdata = rd_q;
    assign s_rresp = rr_q;
    assign cs_n = pin_q.cs_n;
    assign wr_n = pin_q.wr_n;
    assign rd_n = pin_q.rd_n;
    assign a0 = pin_q.a0;
    assign intr_ack_strobe_n = pin_q.ack_n;
    assign data_out = pin_q.dout;
    assign data_oe = pin_q.doe;
endmodule : pic_host_ctrl
`default_nettype wire

/* File: verification/pic_dev_model.sv */
// device model: command decoding and acknowledge bytes of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module pic_dev_model (
    // host side pins
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic a0,
    input wire logic intr_ack_strobe_n,
    input wire logic [7:0] data_out,
    output logic [7:0] data_in,
    output logic intr_req,
    // request stimulus
    input wire logic req,
    input wire logic [2:0] lvl
);
    logic [7:0] w1_q, w2_q, w3_q, mask_q, val, last;
    logic [2:0] init_q, slave_id_q;
    logic [1:0] ack_q;
    logic cpu16_q, lt_q, smm_q, in_ack, drv;
    initial
    begin
        {init_q, mask_q, ack_q, cpu16_q, last, in_ack, w1_q, w2_q} = '0;
    end
    always @(posedge wr_n)
        if (!cs_n)
        begin
            if (!a0 && data_out[4])
            begin
                w1_q = data_out;
                init_q = 3'h2;
                mask_q = 8'h00;
                slave_id_q = 3'h7;
                smm_q = 1'b0;
                cpu16_q = 1'b0;
                lt_q = data_out[3];
            end
            else if (!a0)
            begin
                if (data_out[3] && data_out[6])
                    smm_q = data_out[5];
            end
            else
                case (init_q)
                    3'h2: begin w2_q = data_out; init_q = w1_q[1] ? (w1_q[0] ? 3'h4 : 3'h0) : 3'h3; end
                    3'h3: begin w3_q = data_out; init_q = w1_q[0] ? 3'h4 : 3'h0; end
                    3'h4: begin cpu16_q = data_out[0]; init_q = 3'h0; end
                    default: mask_q = data_out;
                endcase
        end
    // guard against the reset-time rise of the strobe
    always @(negedge intr_ack_strobe_n) in_ack = 1'b1;
    always @(posedge intr_ack_strobe_n)
        if (in_ack)
        begin
            in_ack = 1'b0;
            ack_q = (ack_q == (cpu16_q ? 2'h1 : 2'h2)) ? 2'h0 : ack_q + 2'h1;
        end
    always_comb
        case (ack_q)
            2'h0: val = 8'hcd;
            2'h1: val = cpu16_q ? {w2_q[7:3], lvl}
                : w1_q[2] ? {w1_q[7:5], lvl, 2'h0} : {w1_q[7:6], lvl, 3'h0};
            default: val = w2_q;
        endcase
    assign drv = (!rd_n && !cs_n) || (!intr_ack_strobe_n && !(cpu16_q && ack_q == 2'h0));
    // released bus shows the inverse of its last value, never a stale copy
    assign data_in = drv ? (!rd_n ? mask_q : val) : ~last;
    always @(data_in) if (drv) last = data_in;
    assign intr_req = req && !mask_q[lvl];
endmodule : pic_dev_model
`default_nettype wire

/* File: verification/pic_host_ctrl_checker.sv */
// checker: device pin timing of the interrupt controller host
`timescale 1ns/1ps
`default_nettype none
module pic_host_ctrl_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // device pins
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic a0,
    input wire logic intr_ack_strobe_n,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wr_select_a: assert property (!wr_n |-> !cs_n)
        else $error("write strobe without chip select");
    rd_select_a: assert property (!rd_n |-> !cs_n && a0)
        else $error("read strobe without chip select or a0");
    strobe_excl_a: assert property ($onehot0({!wr_n, !rd_n, !intr_ack_strobe_n}))
        else $error("two strobes low at once");
    wr_width_a: assert property ($fell(wr_n) |-> (!wr_n) [*4] ##1 wr_n)
        else $error("write strobe width wrong");
    ack_width_a: assert property ($fell(intr_ack_strobe_n) |-> (!intr_ack_strobe_n) [*4] ##1 intr_ack_strobe_n)
        else $error("acknowledge strobe width wrong");
    wr_setup_a: assert property ($fell(wr_n) |-> !$past(cs_n, 2) && $past(data_oe, 2))
        else $error("write data not set up before strobe");
    wr_hold_a: assert property (!wr_n && $past(!wr_n) |-> $stable(data_out) && $stable(a0))
        else $error("write data moved under strobe");
    wr_drive_a: assert property (!wr_n |-> data_oe)
        else $error("write strobe with bus released");
    bus_float_a: assert property (!intr_ack_strobe_n || !rd_n |-> !data_oe)
        else $error("host drives bus while device answers");
    wr_seen_c: cover property ($fell(wr_n));
    ack_seen_c: cover property ($fell(intr_ack_strobe_n));
    rd_seen_c: cover property ($fell(rd_n));
endmodule : pic_host_ctrl_checker
bind pic_host_ctrl pic_host_ctrl_checker chk (.core_clk, .arst_n, .cs_n, .wr_n, .rd_n, .a0,
    .intr_ack_strobe_n, .data_out, .data_oe);
`default_nettype wire

/* File: verification/prog_interrupt_ctrl_vector_cmd_test.sv */
// testbench: axi command traffic against a behavioural interrupt controller
`timescale 1ns/1ps
`default_nettype none
module prog_interrupt_ctrl_vector_cmd_test
    import pic_host_pkg::*;
;
    logic core_clk, arst_n, req, cs_n, wr_n, rd_n, a0, intr_ack_strobe_n, data_oe, intr_req;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [7:0] s_awaddr, s_araddr, data_out, data_in, w1, w2, m;
    logic [31:0] s_wdata, s_rdata, rd, ex, seed;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    logic [2:0] lvl;
    logic [65:0] ex_r;
    logic [1:0] eb[$];
    logic [65:0] er[$];
    int bad_count, compares;
    pic_host_ctrl dut (.core_clk, .arst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .cs_n, .wr_n, .rd_n, .a0, .intr_ack_strobe_n,
        .data_out, .data_oe, .data_in, .intr_req);
    pic_dev_model dev (.cs_n, .wr_n, .rd_n, .a0, .intr_ack_strobe_n, .data_out, .data_in,
        .intr_req, .req, .lvl);
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    // handshakes are judged at the falling edge so no race with the design's edge
    task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] st,
        input logic [1:0] rs);
        logic ta, tw, tb;
        eb.push_back(rs);
        s_awaddr <= ad;
        s_wdata <= d;
        s_wstrb <= st;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge core_clk);
            ta = s_awvalid && s_awready;
            tw = s_wvalid && s_wready;
            tb = s_bvalid;
            @(posedge core_clk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
        end
    endtask : axw
    task automatic axr(input logic [7:0] ad, input logic [31:0] e, mk, input logic [1:0] rs,
        output logic [31:0] d);
        logic ta, tr;
        er.push_back({mk, e, rs});
        s_araddr <= ad;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge core_clk);
            ta = s_arvalid && s_arready;
            tr = s_rvalid;
            d = s_rdata;
            @(posedge core_clk);
            if (ta) s_arvalid <= 1'b0;
        end
    endtask : axr
    task automatic idle();
        logic [31:0] st;
        st = 32'h40;
        for (int i = 0; i < 60 && st[6] !== 1'b0; i++)
            axr(STAT_OFF, 32'h0, 32'h0, 2'h0, st);
    endtask : idle
    task automatic cmd(input logic [2:0] c, input logic [7:0] b);
        axw(CMD_OFF, {21'h0, c, b}, 4'h3, 2'h0);
        idle();
    endtask : cmd
    task automatic rdmask(input logic [7:0] v);
        cmd(CMD_RD_A1, 8'h00);
        axr(MASK_OFF, {24'h0, v}, 32'hff, 2'h0, rd);
    endtask : rdmask
    always @(negedge core_clk)
    begin
        if (s_bvalid && s_bready && eb.size() > 0)
            check("bresp", {30'h0, s_bresp}, {30'h0, eb.pop_front()});
        if (s_rvalid && s_rready && er.size() > 0)
        begin
            ex_r = er.pop_front();
            check("rresp", {30'h0, s_rresp}, {30'h0, ex_r[1:0]});
            check("rdata", s_rdata & ex_r[65:34], ex_r[33:2] & ex_r[65:34]);
        end
    end
    initial
    begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        end_sim();
    end
    initial
    begin
        {arst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, req} = '0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb, lvl} = '0;
        seed = 32'h89994dee;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        axw(STAT_OFF, 32'h0, 4'hf, 2'h2);
        axw(CMD_OFF, 32'h16, 4'h1, 2'h2);
        axr(8'h20, 32'h0, 32'hffffffff, 2'h2, rd);
        for (int iv = 0; iv < 2; iv++)
        begin
            seed = lfsr(seed);
            w1 = {seed[7:5], 2'h2, iv[0], 2'h2};
            w2 = seed[15:8];
            cmd(CMD_WR_A0, w1);
            cmd(CMD_WR_A1, w2);
            for (int lv = 0; lv < 8; lv++)
            begin
                lvl <= 3'(lv);
                cmd(CMD_ACK, 8'h00);
                ex = {8'h0, 8'hcd, ((iv == 1) ? {w1[7:5], 3'(lv), 2'h0} : {w1[7:6], 3'(lv), 3'h0}), w2};
                axr(VEC_OFF, ex, 32'hffffff, 2'h0, rd);
            end
        end
        rdmask(8'h00);
        seed = lfsr(seed);
        m = seed[7:0] | 8'h08;
        cmd(CMD_WR_A1, m);
        rdmask(m);
        req <= 1'b1;
        lvl <= 3'h3;
        cmd(CMD_WR_A1, m);
        axr(STAT_OFF, 32'h0, 32'h80, 2'h0, rd);
        cmd(CMD_WR_A1, m & 8'hf7);
        axr(STAT_OFF, 32'h80, 32'h80, 2'h0, rd);
        seed = lfsr(seed);
        w2 = seed[7:0];
        cmd(CMD_WR_A0, 8'h11);
        cmd(CMD_WR_A1, 8'h3c);
        cmd(CMD_WR_A0, 8'h11);
        cmd(CMD_WR_A1, w2);
        cmd(CMD_WR_A1, 8'h00);
        cmd(CMD_WR_A1, 8'h01);
        cmd(CMD_WR_A1, 8'ha5);
        rdmask(8'ha5);
        lvl <= 3'h5;
        cmd(CMD_ACK, 8'h00);
        axr(VEC_OFF, {24'h0, w2[7:3], 3'h5}, 32'hff, 2'h0, rd);
        axw(CMD_OFF, {21'h0, CMD_WR_A0, 8'h68}, 4'h3, 2'h0);
        axw(CMD_OFF, {21'h0, CMD_WR_A0, 8'h48}, 4'h3, 2'h2);
        idle();
        cmd(CMD_WR_A0, 8'h20);
        axr(SHADOW_OFF, {16'h0049, w2, 8'h00}, 32'hffffffff, 2'h0, rd);
        cmd(CMD_WR_A0, 8'h16);
        rdmask(8'h00);
        cmd(CMD_WR_A1, w2);
        axr(SHADOW_OFF, {16'h0180, w2, 8'h07}, 32'hffffffff, 2'h0, rd);
        cmd(CMD_ACK, 8'h00);
        axr(VEC_OFF, {8'h0, 8'hcd, 8'h14, w2}, 32'hffffff, 2'h0, rd);
        repeat (4) @(posedge core_clk);
        end_sim();
    end
endmodule : prog_interrupt_ctrl_vector_cmd_test
`default_nettype wire
